/* File: core/mesc_counters.sv */
// MAC error statistics counters with APB slave and event interrupt.
// Assumes frame status inputs are synchronous one-cycle strobes on pclk.

`timescale 1ns/100ps
`default_nettype none

module mesc_counters (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              irq,
  // Transmit frame end status
  input  wire  logic        tx_done,
  input  wire  logic        tx_excess_col,
  input  wire  logic        tx_underrun,
  input  wire  logic        tx_carrier_err,
  input  wire  logic        tx_en,
  input  wire  logic        collision_detect_signal,
  // Receive frame end status
  input  wire  logic        rx_done,
  input  wire  logic [15:0] rx_len,
  input  wire  logic        rx_crc_err,
  input  wire  logic        rx_align_err,
  input  wire  logic        rx_sym_err,
  input  wire  logic [15:0] rx_len_field,
  input  wire  logic        rx_no_buffer,
  input  wire  logic        rx_dma_overrun,
  output logic              rx_fcs_or_align
);

  // ****************************************
  // Counters
  // ****************************************
  logic [7:0]  excess_collision_field_q;
  logic [7:0]  tx_underrun_field_q;
  logic [7:0]  carrier_loss_field_q;
  logic [15:0] rx_no_buffer_field_q;
  logic [7:0]  rx_dma_overrun_field_q;
  logic [7:0]  rx_symbol_fault_field_q;
  logic [7:0]  oversize_clean_field_q;
  logic [7:0]  oversize_bad_field_q;
  logic [7:0]  runt_clean_field_q;
  logic [7:0]  heartbeat_fail_field_q;
  logic [7:0]  length_mismatch_field_q;
  logic [31:0] cfg_q;
  logic [10:0] isr_q;
  logic [10:0] imr_q;
  logic [11:0] hb_cnt_q;
  logic        hb_arm_q;
  logic        tx_en_q;

  logic        wr;
  logic        rd;
  logic [15:0] max_len;
  logic        rx_bad;
  logic        ev_excess_collision_field;
  logic        ev_tx_underrun_field;
  logic        ev_cse;
  logic        ev_rre;
  logic        ev_rx_dma_overrun_field;
  logic        ev_rse;
  logic        ev_ele;
  logic        ev_rja;
  logic        ev_usf;
  logic        ev_ste;
  logic        ev_rle;
  logic [10:0] ev;

  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + 8'h01;
  endfunction

  function automatic logic wsel(input logic [7:0] off);
    wsel = wr && (paddr == off);
  endfunction

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ****************************************
  // Event decode
  // ****************************************
  assign max_len = cfg_q[mesc_pkg::MESC_CFG_BIG_POS] ? mesc_pkg::MESC_MAX_LEN_BIG
                                                     : mesc_pkg::MESC_MAX_LEN;
  assign rx_bad  = rx_crc_err || rx_align_err || rx_sym_err;

  // Underrun suppresses the excess collision and carrier error events for that frame
  assign ev_tx_underrun_field  = tx_done && tx_underrun;
  assign ev_excess_collision_field = tx_done && tx_excess_col && !tx_underrun;
  // Carrier error counts only in half duplex, and only when there is no underrun and no excess collision
  assign ev_cse   = tx_done && tx_carrier_err && !tx_underrun
                    && !tx_excess_col
                    && !cfg_q[mesc_pkg::MESC_CFG_FD_POS];
  assign ev_rre   = rx_done && rx_no_buffer;
  assign ev_rx_dma_overrun_field  = rx_done && rx_dma_overrun;
  assign ev_rse   = rx_done && rx_sym_err;
  assign ev_ele   = rx_done && (rx_len > max_len) && !rx_bad;
  assign ev_rja   = rx_done && (rx_len > max_len) && rx_bad;
  assign ev_usf   = rx_done && (rx_len < mesc_pkg::MESC_MIN_LEN) && !rx_bad;
  assign ev_rle   = rx_done && cfg_q[mesc_pkg::MESC_CFG_LCHK_POS]
                    && (rx_len_field < mesc_pkg::MESC_TYPE_MIN)
                    && (rx_len <= max_len)
                    && (rx_len < rx_len_field);
  assign ev_ste   = hb_arm_q && (hb_cnt_q == 12'h000)
                    && !collision_detect_signal;
  assign ev = {ev_rle, ev_ste, ev_usf, ev_rja, ev_ele, ev_rse,
               ev_rx_dma_overrun_field, ev_rre, ev_cse, ev_tx_underrun_field, ev_excess_collision_field};

  // Handed to the CRC/alignment counters outside this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fcs_or_align <= 1'b0;
    end else begin
      rx_fcs_or_align <= rx_done && rx_sym_err
                         && (rx_len >= mesc_pkg::MESC_MIN_LEN)
                         && (rx_len <= max_len);
    end
  end

  // ****************************************
  // Heartbeat window after tx_en falls
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_q  <= 1'b0;
      hb_arm_q <= 1'b0;
      hb_cnt_q <= 12'h000;
    end else begin
      tx_en_q <= tx_en;
      if (tx_en_q && !tx_en && !cfg_q[mesc_pkg::MESC_CFG_FD_POS]) begin
        hb_arm_q <= 1'b1;
        hb_cnt_q <= mesc_pkg::MESC_HB_CYC;
      end else if (hb_arm_q && (collision_detect_signal || hb_cnt_q == 12'h000)) begin
        hb_arm_q <= 1'b0;
      end else if (hb_arm_q) begin
        hb_cnt_q <= hb_cnt_q - 12'h001;
      end
    end
  end

  // ****************************************
  // Counter updates; a software write wins
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      excess_collision_field_q <= mesc_pkg::MESC_CNT8_RST;
      tx_underrun_field_q      <= mesc_pkg::MESC_CNT8_RST;
      carrier_loss_field_q     <= mesc_pkg::MESC_CNT8_RST;
      rx_no_buffer_field_q     <= mesc_pkg::MESC_CNT16_RST;
      rx_dma_overrun_field_q   <= mesc_pkg::MESC_CNT8_RST;
      rx_symbol_fault_field_q  <= mesc_pkg::MESC_CNT8_RST;
      oversize_clean_field_q   <= mesc_pkg::MESC_CNT8_RST;
      oversize_bad_field_q     <= mesc_pkg::MESC_CNT8_RST;
      runt_clean_field_q       <= mesc_pkg::MESC_CNT8_RST;
      heartbeat_fail_field_q   <= mesc_pkg::MESC_CNT8_RST;
      length_mismatch_field_q  <= mesc_pkg::MESC_CNT8_RST;
    end else begin
      // Write loads low bits only
      if (wsel(mesc_pkg::MESC_EXCESS_COLLISION_FIELD_OFF)) excess_collision_field_q <= pwdata[7:0];
      else if (ev_excess_collision_field) excess_collision_field_q <= inc8(excess_collision_field_q);
      if (wsel(mesc_pkg::MESC_TX_UNDERRUN_FIELD_OFF)) tx_underrun_field_q <= pwdata[7:0];
      else if (ev_tx_underrun_field) tx_underrun_field_q <= inc8(tx_underrun_field_q);
      if (wsel(mesc_pkg::MESC_CSE_OFF)) carrier_loss_field_q <= pwdata[7:0];
      else if (ev_cse) carrier_loss_field_q <= inc8(carrier_loss_field_q);
      if (wsel(mesc_pkg::MESC_RRE_OFF)) rx_no_buffer_field_q <= pwdata[15:0];
      else if (ev_rre) rx_no_buffer_field_q <= rx_no_buffer_field_q + 16'h0001;
      if (wsel(mesc_pkg::MESC_RX_DMA_OVERRUN_FIELD_OFF)) rx_dma_overrun_field_q <= pwdata[7:0];
      else if (ev_rx_dma_overrun_field) rx_dma_overrun_field_q <= inc8(rx_dma_overrun_field_q);
      if (wsel(mesc_pkg::MESC_RSE_OFF)) rx_symbol_fault_field_q <= pwdata[7:0];
      else if (ev_rse) rx_symbol_fault_field_q <= inc8(rx_symbol_fault_field_q);
      if (wsel(mesc_pkg::MESC_ELE_OFF)) oversize_clean_field_q <= pwdata[7:0];
      else if (ev_ele) oversize_clean_field_q <= inc8(oversize_clean_field_q);
      if (wsel(mesc_pkg::MESC_RJA_OFF)) oversize_bad_field_q <= pwdata[7:0];
      else if (ev_rja) oversize_bad_field_q <= inc8(oversize_bad_field_q);
      if (wsel(mesc_pkg::MESC_USF_OFF)) runt_clean_field_q <= pwdata[7:0];
      else if (ev_usf) runt_clean_field_q <= inc8(runt_clean_field_q);
      if (wsel(mesc_pkg::MESC_STE_OFF)) heartbeat_fail_field_q <= pwdata[7:0];
      else if (ev_ste) heartbeat_fail_field_q <= inc8(heartbeat_fail_field_q);
      if (wsel(mesc_pkg::MESC_RLE_OFF)) length_mismatch_field_q <= pwdata[7:0];
      else if (ev_rle) length_mismatch_field_q <= inc8(length_mismatch_field_q);
    end
  end

  // ****************************************
  // Configuration, interrupt status and mask
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= mesc_pkg::MESC_CFG_RST;
      imr_q <= 11'h000;
    end else begin
      if (wsel(mesc_pkg::MESC_CFG_OFF)) cfg_q <= pwdata;
      if (wsel(mesc_pkg::MESC_IMR_OFF)) imr_q <= pwdata[10:0];
    end
  end

  // New events win over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_q <= 11'h000;
    end else if (wsel(mesc_pkg::MESC_ISR_OFF)) begin
      isr_q <= (isr_q & ~pwdata[10:0]) | ev;
    end else begin
      isr_q <= isr_q | ev;
    end
  end

  assign irq = |(isr_q & imr_q);

  // ****************************************
  // Read data; unmapped reads return zero
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      unique case (paddr)
        mesc_pkg::MESC_EXCESS_COLLISION_FIELD_OFF: prdata <= {24'h000000, excess_collision_field_q};
        mesc_pkg::MESC_TX_UNDERRUN_FIELD_OFF:  prdata <= {24'h000000, tx_underrun_field_q};
        mesc_pkg::MESC_CSE_OFF:   prdata <= {24'h000000, carrier_loss_field_q};
        mesc_pkg::MESC_RRE_OFF:   prdata <= {16'h0000, rx_no_buffer_field_q};
        mesc_pkg::MESC_RX_DMA_OVERRUN_FIELD_OFF:  prdata <= {24'h000000, rx_dma_overrun_field_q};
        mesc_pkg::MESC_RSE_OFF:   prdata <= {24'h000000, rx_symbol_fault_field_q};
        mesc_pkg::MESC_ELE_OFF:   prdata <= {24'h000000, oversize_clean_field_q};
        mesc_pkg::MESC_RJA_OFF:   prdata <= {24'h000000, oversize_bad_field_q};
        mesc_pkg::MESC_USF_OFF:   prdata <= {24'h000000, runt_clean_field_q};
        mesc_pkg::MESC_STE_OFF:   prdata <= {24'h000000, heartbeat_fail_field_q};
        mesc_pkg::MESC_RLE_OFF:   prdata <= {24'h000000, length_mismatch_field_q};
        mesc_pkg::MESC_CFG_OFF:   prdata <= cfg_q;
        mesc_pkg::MESC_ISR_OFF:   prdata <= {21'h00000, isr_q};
        mesc_pkg::MESC_IMR_OFF:   prdata <= {21'h00000, imr_q};
        default:                  prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: core/mesc_pkg.sv */
// Constants for the MAC error statistics counter block.
// Assumes an APB master on pclk and frame status strobes from the MAC engines.

package mesc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] MESC_EXCESS_COLLISION_FIELD_OFF = 8'h00;
  localparam logic [7:0] MESC_TX_UNDERRUN_FIELD_OFF  = 8'h04;
  localparam logic [7:0] MESC_CSE_OFF   = 8'h08;
  localparam logic [7:0] MESC_RRE_OFF   = 8'h0c;
  localparam logic [7:0] MESC_RX_DMA_OVERRUN_FIELD_OFF  = 8'h10;
  localparam logic [7:0] MESC_RSE_OFF   = 8'h14;
  localparam logic [7:0] MESC_ELE_OFF   = 8'h18;
  localparam logic [7:0] MESC_RJA_OFF   = 8'h1c;
  localparam logic [7:0] MESC_USF_OFF   = 8'h20;
  localparam logic [7:0] MESC_STE_OFF   = 8'h24;
  localparam logic [7:0] MESC_RLE_OFF   = 8'h28;
  localparam logic [7:0] MESC_CFG_OFF   = 8'h2c;
  localparam logic [7:0] MESC_ISR_OFF   = 8'h30;
  localparam logic [7:0] MESC_IMR_OFF   = 8'h34;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         MESC_CFG_BIG_POS  = 8;
  localparam int         MESC_CFG_LCHK_POS = 16;
  localparam int         MESC_CFG_FD_POS   = 0;
  localparam int         MESC_NEV          = 11;
  localparam logic [7:0]  MESC_CNT8_RST    = 8'h00;
  localparam logic [15:0] MESC_CNT16_RST   = 16'h0000;
  localparam logic [31:0] MESC_CFG_RST     = 32'h0000_0000;

  // ****************************************
  // Frame length limits
  // ****************************************
  localparam logic [15:0] MESC_MIN_LEN      = 16'h0040;
  localparam logic [15:0] MESC_MAX_LEN      = 16'h05ee;
  localparam logic [15:0] MESC_MAX_LEN_BIG  = 16'h0600;
  localparam logic [15:0] MESC_TYPE_MIN     = 16'h0600;

  // ****************************************
  // Heartbeat window: 96 bit times
  // ****************************************
  localparam int          MESC_HB_BITS      = 96;
  localparam int          MESC_CLK_MHZ      = 125;
  // 10 Mb/s: 100 ns per bit; longest time rounds down
  localparam int          MESC_HB_NS        = MESC_HB_BITS * 100;
  localparam int          MESC_HB_CYC_I     = (MESC_HB_NS * MESC_CLK_MHZ) / 1000;
  localparam logic [11:0] MESC_HB_CYC       = 12'(MESC_HB_CYC_I);

endpackage

/* File: sim/mesc_counters_chk.sv */
// Checker for the error counter block ports.
// Assumes bound onto mesc_counters; one pclk domain.
`timescale 1ns/100ps
`default_nettype none
module mesc_counters_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        rx_done,
  input wire logic [15:0] rx_len,
  input wire logic        rx_sym_err,
  input wire logic        rx_fcs_or_align
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Assertions
  // ****************************************
  a_fcs_valid_len: assert property (rx_done && rx_sym_err && rx_len >= 16'h0040
    && rx_len <= 16'h05ee |=> rx_fcs_or_align) else $error("fcs flag missing");
  a_fcs_needs_sym: assert property (rx_fcs_or_align |-> $past(rx_done && rx_sym_err))
    else $error("fcs flag without symbol error");
  a_fcs_runt_none: assert property (rx_done && rx_len < 16'h0040 |=> !rx_fcs_or_align)
    else $error("fcs flag on runt");
  a_fcs_jabber_none: assert property (rx_done && rx_len > 16'h0600 |=> !rx_fcs_or_align)
    else $error("fcs flag on jabber");
  a_unmapped_read_zero: assert property (psel && !penable && !pwrite && paddr > 8'h34
    |=> prdata == 32'h0) else $error("unmapped read not zero");
  a_narrow_upper_zero: assert property (psel && penable && !pwrite && paddr <= 8'h28
    && paddr != 8'h0c |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_wide_upper_zero: assert property (psel && penable && !pwrite && paddr == 8'h0c
    |-> prdata[31:16] == 16'h0) else $error("upper bits set");
  a_ready_no_error: assert property (psel && penable |-> pready && !pslverr)
    else $error("bad access answer");
  a_irq_mask_off: assert property (psel && penable && pwrite && paddr == 8'h34
    && pwdata[10:0] == 11'h0 |=> !irq) else $error("irq while masked");
endmodule
bind mesc_counters mesc_counters_chk mesc_counters_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .rx_done(rx_done),
  .rx_len(rx_len), .rx_sym_err(rx_sym_err), .rx_fcs_or_align(rx_fcs_or_align));
`default_nettype wire

/* File: sim/mesc_phy_model.sv */
// PHY stand-in on the MII side: collision heartbeat after each frame.
// Assumes tx_en driven on pclk; hb_on selects a healthy or failed heartbeat.
`timescale 1ns/100ps
`default_nettype none
module mesc_phy_model (
  input  wire logic pclk,
  input  wire logic tx_en,
  input  wire logic hb_on,
  output logic      col
);
  logic       en_q = 1'b0;
  logic [3:0] n_q  = 4'h0;
  // Pulse well inside the 96 bit-time window
  always_ff @(posedge pclk) begin
    en_q <= tx_en;
    if (en_q && !tx_en && hb_on) begin
      n_q <= 4'hf;
    end else if (n_q != 4'h0) begin
      n_q <= n_q - 4'h1;
    end
  end
  assign col = (n_q == 4'h1);
endmodule
`default_nettype wire

/* File: sim/tb_mac_error_statistics_counters.sv */
// Self-checking bench: random frame status, APB register checks, heartbeat.
// Assumes mesc_counters, mesc_phy_model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_mac_error_statistics_counters;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, fcs;
  logic        tx_done, ec, un, ce, tx_en, col, hb_on;
  logic        rx_done, crc, al, sym, nb, ov;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, cfg, r;
  logic [15:0] ln, lf;
  logic [15:0] exp_cnt [11];
  logic [10:0] exp_isr;
  logic [15:0] lens [8] = '{16'h0010, 16'h003f, 16'h0040, 16'h05ee,
                            16'h05ef, 16'h0600, 16'h0601, 16'h07d0};
  int          bad_count, compares, cyc, seed, i, k, n;
  mesc_counters mesc_counters_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .tx_done(tx_done), .tx_excess_col(ec),
    .tx_underrun(un), .tx_carrier_err(ce), .tx_en(tx_en), .collision_detect_signal(col),
    .rx_done(rx_done), .rx_len(ln), .rx_crc_err(crc), .rx_align_err(al), .rx_sym_err(sym),
    .rx_len_field(lf), .rx_no_buffer(nb), .rx_dma_overrun(ov), .rx_fcs_or_align(fcs));
  mesc_phy_model mesc_phy_model_i (.pclk(pclk), .tx_en(tx_en), .hb_on(hb_on), .col(col));
  // ****************************************
  // Tasks and expectation functions
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, want);
    end
  endtask
  task final_report;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Entered just after an edge; trailing edge keeps back-to-back calls apart
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function logic [10:0] tx_inc(input logic e, u, c, fd);
    tx_inc = u ? 11'h002 : {8'h0, c && !fd && !e, 1'b0, e};
  endfunction
  function logic [10:0] rx_inc(input logic [15:0] l, f, input logic bad, s, b, v, big, lc);
    logic [15:0] mx;
    mx = big ? 16'h0600 : 16'h05ee;
    rx_inc = {lc && f < 16'h0600 && l <= mx && l < f, 1'b0, l < 16'h0040 && !bad,
              l > mx && bad, l > mx && !bad, s, v, b, 3'h0};
  endfunction
  task read_all;
    for (i = 0; i < 11; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, {16'h0, exp_cnt[i]});
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, tx_done, ec, un, ce, tx_en, hb_on} = '0;
    {rx_done, crc, al, sym, nb, ov, paddr, pwdata, ln, lf, exp_isr} = '0;
    seed = 86061;
    for (i = 0; i < 11; i++) exp_cnt[i] = 16'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    read_all;
    apb(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h0);
    // Start at all ones so random traffic crosses the wrap
    for (k = 0; k < 11; k++) begin
      apb(1'b1, 8'(k * 4), 32'hffff_ffff);
      exp_cnt[k] = (k == 3) ? 16'hffff : 16'h00ff;
    end
    read_all;
    for (n = 0; n < 80; n++) begin
      cfg = $random(seed) & 32'h0001_0101;
      apb(1'b1, 8'h2c, cfg);
      r = $random(seed);
      {ec, un, ce} <= {r[28], r[29] & r[30], r[31]};
      {crc, al, sym, nb, ov} <= {r[20] & r[21], r[22] & r[23], r[24] & r[25], r[26], r[27]};
      ln <= lens[r[6:4]];
      lf <= r[7] ? 16'h0600 + 16'(r[15:8]) : {5'h0, r[18:8]};
      tx_done <= 1'b1;
      rx_done <= 1'b1;
      @(posedge pclk);
      tx_done <= 1'b0;
      rx_done <= 1'b0;
      @(posedge pclk);
      r[10:0] = tx_inc(ec, un, ce, cfg[0]) | rx_inc(ln, lf, crc | al | sym, sym, nb, ov,
                                                     cfg[8], cfg[16]);
      for (k = 0; k < 11; k++) if (r[k])
        exp_cnt[k] = (k == 3) ? exp_cnt[k] + 16'h1 : {8'h0, exp_cnt[k][7:0] + 8'h1};
      exp_isr = exp_isr | r[10:0];
    end
    read_all;
    apb(1'b0, 8'h30, 32'h0);
    check(rd, {21'h0, exp_isr});
    apb(1'b1, 8'h34, 32'h7ff);
    check({31'h0, irq}, {31'h0, |exp_isr});
    apb(1'b1, 8'h34, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h34, 32'h7ff);
    apb(1'b1, 8'h30, 32'h7ff);
    check({31'h0, irq}, 32'h0);
    // Heartbeat: healthy, missing, then missing in full duplex
    for (n = 0; n < 3; n++) begin
      hb_on <= (n == 0);
      apb(1'b1, 8'h2c, {31'h0, n == 2});
      tx_en <= 1'b1;
      repeat (8) @(posedge pclk);
      tx_en <= 1'b0;
      repeat (1300) @(posedge pclk);
      if (n == 1) exp_cnt[9] = {8'h0, exp_cnt[9][7:0] + 8'h1};
      apb(1'b0, 8'h24, 32'h0);
      check(rd, {16'h0, exp_cnt[9]});
    end
    final_report;
  end
endmodule
`default_nettype wire
